// ==== charger_state_control.sv ====
// Charger state machine, safety timers, protections and APB registers
`timescale 1ns/10ps

// How it works
// - Top-off entered only from CV after current below top-off level for termination delay.
// - After top-off time spent in top-off, move to done.
// - From top-off or done, battery below restart level returns to CC.
// - Done state delivers zero charge current.
// - No soft-start when moving from done back to CC.
// - Prequal states bounded by prequal time, CC plus CV by fast-charge time.
// - Timer fault turns charging off and drives status output low.
// - Junction over shutdown threshold from any state enters thermal shutdown, charger off.
// - Boost-enable high runs reverse boost toward bypass node and charger input.
// - Input overload in reverse boost opens input switch, retries after fixed delay.
// - Persistent overload cycles input switch about 60 ms on, 300 ms off.
// - Boost-enable and standby both high feed only the bypass node.
// - System rail below power-up voltage limits battery-to-system current.
// - Battery overcurrent for overcurrent delay opens battery switch, stops buck.
// - After trip, system rail low for retry time restarts, repeating until cleared.
// - Above foldback temperature, target drops 5 percent per degree.
// - Target reaches zero 20 degrees above foldback set point.
// - Cold-to-cool zone halves fast-charge current in temperature-compliant variant.
// - Warm-to-hot zone lowers termination voltage by 150 mV.
// - Below cold or above hot, charging suspended.
// - Phosphate variant skips warm and cool adjustments, stops only at extremes.
// - Invalid input or suspended timer enters initial state, zero current, timer cleared.
module charger_state_control (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Pins and comparators, asynchronous
    input  wire logic                boostEnablePin,
    input  wire logic                standbyPin,
    input  wire charger_pkg::sense_s sense,
    // Status pin and power path
    output logic                     statusOut,
    output logic                     statusOe,
    output charger_pkg::power_s      power
);
    import charger_pkg::*;

    // Two-flop synchronisers
    sense_s sense1_q, senseS_q;
    logic [1:0] pins1_q, pinsS_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sense1_q <= '0;
            senseS_q <= '0;
            pins1_q  <= '0;
            pinsS_q  <= '0;
        end else begin
            sense1_q <= sense;
            senseS_q <= sense1_q;
            pins1_q  <= {boostEnablePin, standbyPin};
            pinsS_q  <= pins1_q;
        end
    end

    wire boostEn = pinsS_q[1];
    wire standby = pinsS_q[0];

    // Registers
    logic [31:0] ctrl_q, termDly_q, topoff_q, prequal_q, fastchg_q, ovcDly_q, ovcRetry_q;
    logic [15:0] regMv_q;

    wire phosphate = ctrl_q[CTRL_PHOSPHATE];
    wire chgDisable = ctrl_q[CTRL_CHGDIS];

    // Charger state
    chg_state_e state_q, state_d;
    logic [31:0] stateCnt_q;
    logic [31:0] fcCnt_q;
    logic [31:0] termCnt_q;
    logic        inputSeen_q;

    // Temperature zones
    wire coldStop = senseS_q.tempBelowCold || senseS_q.tempAboveHot;
    wire coolZone = !phosphate && senseS_q.tempBelowCool && !senseS_q.tempBelowCold;
    wire warmZone = !phosphate && senseS_q.tempAboveWarm && !senseS_q.tempAboveHot;

    wire inFast      = (state_q == ST_FASTCC) || (state_q == ST_FASTCV);
    wire inPrequal   = (state_q == ST_PRECHG) || (state_q == ST_TRICKLE);
    wire pqExpired   = inPrequal && (stateCnt_q >= prequal_q);
    wire fcExpired   = inFast && (fcCnt_q >= fastchg_q);
    wire termDone    = (termCnt_q >= termDly_q);
    wire topoffDone  = (state_q == ST_TOPOFF) && (stateCnt_q >= topoff_q);
    wire restartLow  = senseS_q.battBelowRestart;
    wire latchedFault = (state_q == ST_TIMERFAULT) && inputSeen_q;

    // Next state
    always_comb begin
        state_d = state_q;
        if (senseS_q.junctionOverShdn) begin
            state_d = ST_THERMSHDN;
        end else if (!senseS_q.inputValid || senseS_q.timerSuspend) begin
            state_d = ST_INIT;
        end else if (!latchedFault) begin
            unique case (state_q)
                ST_INIT, ST_THERMSHDN: begin
                    state_d = ST_PRECHG;
                end
                ST_PRECHG: begin
                    if (pqExpired) state_d = ST_TIMERFAULT;
                    else if (!senseS_q.battBelowPrechg) state_d = phosphate ? ST_FASTCC : ST_TRICKLE;
                end
                ST_TRICKLE: begin
                    if (pqExpired) state_d = ST_TIMERFAULT;
                    else if (!senseS_q.battBelowTrickle) state_d = ST_FASTCC;
                end
                ST_FASTCC: begin
                    if (fcExpired) state_d = ST_TIMERFAULT;
                    else if (senseS_q.battAtReg) state_d = ST_FASTCV;
                end
                ST_FASTCV: begin
                    if (fcExpired) state_d = ST_TIMERFAULT;
                    else if (termDone) state_d = ST_TOPOFF;
                end
                ST_TOPOFF: begin
                    if (restartLow) state_d = ST_FASTCC;
                    else if (topoffDone) state_d = ST_DONE;
                end
                ST_DONE: begin
                    if (restartLow) state_d = ST_FASTCC;
                end
                ST_TIMERFAULT: begin
                    state_d = ST_TIMERFAULT;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q     <= ST_INIT;
            stateCnt_q  <= '0;
            fcCnt_q     <= '0;
            termCnt_q   <= '0;
            inputSeen_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            inputSeen_q <= senseS_q.inputValid;
            // Restart on every entry
            stateCnt_q  <= (state_d != state_q) ? '0 : stateCnt_q + 32'h1;
            // CC and CV share one timer
            fcCnt_q     <= (state_d == ST_FASTCC || state_d == ST_FASTCV)
                           ? fcCnt_q + 32'h1 : '0;
            termCnt_q   <= (state_q == ST_FASTCV && senseS_q.chgBelowTopoff)
                           ? termCnt_q + 32'h1 : '0;
        end
    end

    // Thermal foldback, permille of fast-charge current
    wire [11:0] foldStep = 12'(FOLDBACK_PCT_PER_C * 10);
    wire [11:0] foldCut  = 12'(senseS_q.degreesOverFoldback) * foldStep;
    wire        foldZero = senseS_q.degreesOverFoldback >= 5'(FOLDBACK_SPAN_C);
    wire [11:0] afterFold = (foldZero || foldCut >= FULL_PERMILLE)
                            ? 12'h000 : FULL_PERMILLE - foldCut;
    wire [11:0] afterCool = coolZone ? 12'((afterFold * COOL_PCT) / 100) : afterFold;

    wire charging = (state_q inside {ST_PRECHG, ST_TRICKLE, ST_FASTCC, ST_FASTCV, ST_TOPOFF})
                    && !coldStop && !chgDisable;

    // Reverse boost overload retry
    typedef enum logic [1:0] {RB_OFF, RB_ON, RB_WAIT} rb_e;
    rb_e rb_q;
    logic [31:0] rbCnt_q;
    wire byPassOnly = boostEn && standby;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rb_q    <= RB_OFF;
            rbCnt_q <= '0;
        end else if (!boostEn || byPassOnly) begin
            rb_q    <= RB_OFF;
            rbCnt_q <= '0;
        end else begin
            unique case (rb_q)
                RB_OFF: begin
                    rb_q    <= RB_ON;
                    rbCnt_q <= '0;
                end
                RB_ON: begin
                    rbCnt_q <= rbCnt_q + 32'h1;
                    // Trip on the first on cycle acts at once, later ones follow the on window
                    if (senseS_q.chgInputOverload && (rbCnt_q >= 32'(ON_CYC) || rbCnt_q == 0)) begin
                        rb_q    <= RB_WAIT;
                        rbCnt_q <= '0;
                    end
                end
                RB_WAIT: begin
                    rbCnt_q <= rbCnt_q + 32'h1;
                    if (rbCnt_q >= 32'(OFF_CYC) - 32'h1) begin
                        rb_q    <= RB_ON;
                        rbCnt_q <= 32'h1;
                    end
                end
            endcase
        end
    end

    // Battery overcurrent trip and retry
    logic        ovcTrip_q;
    logic [31:0] ovcCnt_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ovcTrip_q <= 1'b0;
            ovcCnt_q  <= '0;
        end else if (!ovcTrip_q) begin
            ovcCnt_q <= senseS_q.battOverCurrent ? ovcCnt_q + 32'h1 : '0;
            if (senseS_q.battOverCurrent && ovcCnt_q + 32'h1 >= ovcDly_q) begin
                ovcTrip_q <= 1'b1;
                ovcCnt_q  <= '0;
            end
        end else begin
            ovcCnt_q <= senseS_q.sysBelowPowerup ? ovcCnt_q + 32'h1 : '0;
            if (senseS_q.sysBelowPowerup && ovcCnt_q + 32'h1 >= ovcRetry_q) begin
                ovcTrip_q <= 1'b0;
                ovcCnt_q  <= '0;
            end
        end
    end

    // Power path outputs, all registered
    power_s power_d;
    always_comb begin
        power_d                 = '0;
        power_d.chargeOn        = charging && (state_q != ST_DONE);
        power_d.regulateVoltage = state_q inside {ST_FASTCV, ST_TOPOFF};
        power_d.softStart       = charging && state_q != ST_FASTCC;
        power_d.currentPermille = power_d.chargeOn ? afterCool : 12'h000;
        power_d.regTargetMv     = warmZone ? regMv_q - WARM_DROP_MV : regMv_q;
        power_d.reverseBoost    = boostEn;
        power_d.bypassToInputOn = boostEn && !byPassOnly && rb_q == RB_ON;
        power_d.battSwitchOn    = !ovcTrip_q;
        power_d.buckOn          = !ovcTrip_q && !standby && !boostEn;
        power_d.powerupLimit    = senseS_q.sysBelowPowerup;
    end

    // Status pin: released while charging, driven low otherwise
    always_ff @(posedge clk) begin
        if (!nrst) begin
            power     <= '0;
            statusOut <= 1'b0;
            statusOe  <= 1'b1;
        end else begin
            power     <= power_d;
            statusOut <= 1'b0;
            statusOe  <= !(charging && state_q != ST_TIMERFAULT);
        end
    end

    // APB slave, zero wait states
    wire        wrEn = psel && penable && pwrite;
    wire        mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_TARGET);
    wire [31:0] statusWord = {16'h0000, 3'b000, ovcTrip_q, 2'b00, rb_q, coldStop,
                              coolZone, warmZone, 1'b0, 4'(state_q)};
    logic [31:0] rd;
    always_comb begin
        unique case (paddr)
            OFF_CTRL:     rd = ctrl_q;
            OFF_STATUS:   rd = statusWord;
            OFF_TERMDLY:  rd = termDly_q;
            OFF_TOPOFF:   rd = topoff_q;
            OFF_PREQUAL:  rd = prequal_q;
            OFF_FASTCHG:  rd = fastchg_q;
            OFF_OVCDLY:   rd = ovcDly_q;
            OFF_OVCRETRY: rd = ovcRetry_q;
            OFF_REGMV:    rd = {16'h0000, regMv_q};
            OFF_TARGET:   rd = {20'h00000, power.currentPermille};
            default:      rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_q     <= CTRL_RST;
            termDly_q  <= TERM_DELAY_RST;
            topoff_q   <= TOPOFF_TIME_RST;
            prequal_q  <= PREQUAL_RST;
            fastchg_q  <= FASTCHG_RST;
            ovcDly_q   <= OVC_DELAY_RST;
            ovcRetry_q <= OVC_RETRY_RST;
            regMv_q    <= REGMV_RST;
            prdata     <= '0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd : 32'h0000_0000;
            if (wrEn && pready) begin
                unique case (paddr)
                    OFF_CTRL:     ctrl_q     <= {30'h0, pwdata[1:0]};
                    OFF_TERMDLY:  termDly_q  <= pwdata;
                    OFF_TOPOFF:   topoff_q   <= pwdata;
                    OFF_PREQUAL:  prequal_q  <= pwdata;
                    OFF_FASTCHG:  fastchg_q  <= pwdata;
                    OFF_OVCDLY:   ovcDly_q   <= pwdata;
                    OFF_OVCRETRY: ovcRetry_q <= pwdata;
                    OFF_REGMV:    regMv_q    <= pwdata[15:0];
                    default:      ;
                endcase
            end
        end
    end

endmodule : charger_state_control

// ==== charger_pkg.sv ====
// Package with constants, types and register map of the charger control block
package charger_pkg;

    // Clock
    localparam int unsigned CLK_HZ = 25_000_000;

    // Times in milliseconds and their cycle counts
    localparam int unsigned REVERSE_RETRY_MS = 300;
    localparam int unsigned REVERSE_ON_MS    = 60;
    localparam int unsigned REVERSE_OFF_MS   = 300;
    localparam int unsigned RETRY_CYC        = REVERSE_RETRY_MS * (CLK_HZ / 1000);
    localparam int unsigned ON_CYC           = REVERSE_ON_MS * (CLK_HZ / 1000);
    localparam int unsigned OFF_CYC          = REVERSE_OFF_MS * (CLK_HZ / 1000);

    // Default limits, in cycles, for timers without a figure of their own
    localparam logic [31:0] TERM_DELAY_RST  = 32'h0000_0400;
    localparam logic [31:0] TOPOFF_TIME_RST = 32'h0001_0000;
    localparam logic [31:0] PREQUAL_RST     = 32'h0010_0000;
    localparam logic [31:0] FASTCHG_RST     = 32'h0100_0000;
    localparam logic [31:0] OVC_DELAY_RST   = 32'h0000_0010;
    localparam logic [31:0] OVC_RETRY_RST   = 32'h0001_0000;

    // Thermal and temperature-zone figures
    localparam int unsigned FOLDBACK_PCT_PER_C = 5;
    localparam int unsigned FOLDBACK_SPAN_C    = 20;
    localparam int unsigned COOL_PCT           = 50;
    localparam logic [15:0] WARM_DROP_MV       = 16'h0096;
    localparam logic [11:0] FULL_PERMILLE      = 12'h3e8;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_TERMDLY  = 8'h08;
    localparam logic [7:0] OFF_TOPOFF   = 8'h0c;
    localparam logic [7:0] OFF_PREQUAL  = 8'h10;
    localparam logic [7:0] OFF_FASTCHG  = 8'h14;
    localparam logic [7:0] OFF_OVCDLY   = 8'h18;
    localparam logic [7:0] OFF_OVCRETRY = 8'h1c;
    localparam logic [7:0] OFF_REGMV    = 8'h20;
    localparam logic [7:0] OFF_TARGET   = 8'h24;

    // Control register fields and reset values
    localparam int unsigned CTRL_PHOSPHATE = 0;
    localparam int unsigned CTRL_CHGDIS    = 1;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
    localparam logic [15:0] REGMV_RST      = 16'h1068;

    typedef enum logic [3:0] {
        ST_INIT, ST_PRECHG, ST_TRICKLE, ST_FASTCC, ST_FASTCV,
        ST_TOPOFF, ST_DONE, ST_TIMERFAULT, ST_THERMSHDN
    } chg_state_e;

    // Analog comparator results
    typedef struct packed {
        logic       inputValid;
        logic       timerSuspend;
        logic       battBelowPrechg;
        logic       battBelowTrickle;
        logic       battAtReg;
        logic       battBelowRestart;
        logic       chgBelowTopoff;
        logic       junctionOverShdn;
        logic [4:0] degreesOverFoldback;
        logic       tempBelowCold;
        logic       tempBelowCool;
        logic       tempAboveWarm;
        logic       tempAboveHot;
        logic       sysBelowPowerup;
        logic       battOverCurrent;
        logic       chgInputOverload;
    } sense_s;

    // Power path commands
    typedef struct packed {
        logic        chargeOn;
        logic        regulateVoltage;
        logic        softStart;
        logic [11:0] currentPermille;
        logic [15:0] regTargetMv;
        logic        reverseBoost;
        logic        bypassToInputOn;
        logic        battSwitchOn;
        logic        buckOn;
        logic        powerupLimit;
    } power_s;

endpackage : charger_pkg

// ==== charger_state_control_props.sv ====
// Port-level checker of the charger control block
`timescale 1ns/10ps
module charger_state_control_props (
    // Clock and reset
    input wire logic                clk,
    input wire logic                nrst,
    // APB
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Pins and power path
    input wire logic                boostEnablePin,
    input wire logic                standbyPin,
    input wire charger_pkg::sense_s sense,
    input wire logic                statusOut,
    input wire logic                statusOe,
    input wire charger_pkg::power_s power
);
    import charger_pkg::*;
    // Six cycles cover the two-flop sync plus registered outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_apb_ready: assert property (psel && !penable |=> pready && penable)
        else $error("no ready after setup");
    a_apb_error: assert property (psel && !penable && (paddr[1:0] != 2'b00 || paddr > 8'h24)
        |=> pslverr) else $error("no error on unmapped address");
    a_shdn_off: assert property (sense.junctionOverShdn [*6] |-> !power.chargeOn)
        else $error("charging in shutdown");
    a_cold_hot: assert property ((sense.tempBelowCold || sense.tempAboveHot) [*6]
        |-> !power.chargeOn) else $error("charging at temperature extreme");
    a_no_input: assert property (!sense.inputValid [*6]
        |-> !power.chargeOn && power.currentPermille == 12'h000)
        else $error("charging without input");
    a_fold_zero: assert property ((sense.degreesOverFoldback >= 5'h14) [*6]
        |-> power.currentPermille == 12'h000) else $error("current past foldback span");
    a_byp_only: assert property ((boostEnablePin && standbyPin) [*6]
        |-> !power.bypassToInputOn) else $error("input switch on in bypass boost");
    a_boost_on: assert property ((boostEnablePin && !sense.inputValid
        && !sense.battOverCurrent) [*6] |-> power.reverseBoost) else $error("no reverse boost");
    a_pu_limit: assert property (sense.sysBelowPowerup [*6] |-> power.powerupLimit)
        else $error("no power-up limit");
endmodule : charger_state_control_props

bind charger_state_control charger_state_control_props i_props (.clk, .nrst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .boostEnablePin,
    .standbyPin, .sense, .statusOut, .statusOe, .power);

// ==== charger_host_model.sv ====
// Host pins and comparator levels seen by the charger control block
`timescale 1ns/10ps
module charger_host_model (
    // Clock
    input  wire logic                clk,
    // Requests from the bench
    input  wire charger_pkg::sense_s senseReq,
    input  wire logic                boostReq,
    input  wire logic                standbyReq,
    // Pins and comparator levels
    output charger_pkg::sense_s      sense,
    output logic                     boostEnablePin,
    output logic                     standbyPin
);
    import charger_pkg::*;
    sense_s senseLvl_q = '0;
    logic   boost_q    = 1'b0;
    logic   standby_q  = 1'b0;
    // Levels move one cycle after a request, like a host port
    always @(posedge clk) begin
        senseLvl_q <= senseReq;
        boost_q    <= boostReq;
        standby_q  <= standbyReq;
    end
    assign sense          = senseLvl_q;
    assign boostEnablePin = boost_q;
    assign standbyPin     = standby_q;
endmodule : charger_host_model

// ==== tb_top.sv ====
// Self-checking bench for the charger control block
`timescale 1ns/10ps
module tb_top;
    import charger_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        boostReq = 1'b0;
    logic        standbyReq = 1'b0;
    sense_s      senseReq = '0;
    logic        boostEnablePin;
    logic        standbyPin;
    sense_s      sense;
    logic        statusOut;
    logic        statusOe;
    power_s      power;
    int          num_errors = 0;
    int          check_count = 0;
    logic [31:0] rd;
    logic        err;
    always #20 clk = ~clk;
    charger_host_model i_charger_host_model (.clk, .senseReq, .boostReq, .standbyReq,
        .sense, .boostEnablePin, .standbyPin);
    charger_state_control i_charger_state_control (.clk, .nrst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .boostEnablePin, .standbyPin, .sense,
        .statusOut, .statusOe, .power);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Sample pready and read data at the rising edge that completes the access
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n >= 20) begin
            num_errors++;
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic waitState(input logic [3:0] s);
        apb(1'b0, OFF_STATUS, 32'h0);
        for (int i = 0; i < 100 && rd[3:0] !== s; i++) begin
            apb(1'b0, OFF_STATUS, 32'h0);
        end
        chk({28'h0, rd[3:0]}, {28'h0, s});
    endtask : waitState
    task automatic test_reset;
        chk(32'(statusOe), 32'h1);
        chk(32'(power != '0), 32'h0);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, CTRL_RST);
        apb(1'b0, OFF_REGMV, 32'h0);
        chk(rd, 32'(REGMV_RST));
        apb(1'b0, OFF_TOPOFF, 32'h0);
        chk(rd, TOPOFF_TIME_RST);
        apb(1'b1, 8'h28, 32'hffff_ffff);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h28, 32'h0);
        chk(rd, 32'h0);
        // Short limits keep the termination, top-off, prequal and overcurrent retry timer paths reachable in a few hundred cycles
        apb(1'b1, OFF_TERMDLY, 32'h14);
        apb(1'b1, OFF_TOPOFF, 32'h28);
        apb(1'b1, OFF_PREQUAL, 32'h3c);
        apb(1'b1, OFF_OVCRETRY, 32'h14);
        apb(1'b0, OFF_PREQUAL, 32'h0);
        chk(rd, 32'h3c);
        $display("test reset done");
    endtask : test_reset
    task automatic test_prequal;
        @(posedge clk);
        senseReq.inputValid       <= 1'b1;
        senseReq.battBelowPrechg  <= 1'b1;
        senseReq.battBelowTrickle <= 1'b1;
        waitState(4'h1);
        waitState(4'h7);
        settle;
        chk(32'(power.chargeOn), 32'h0);
        chk(32'(statusOe), 32'h1);
        senseReq.battBelowPrechg <= 1'b0;
        settle;
        waitState(4'h7);
        senseReq.inputValid <= 1'b0;
        waitState(4'h0);
        settle;
        chk(32'(power.currentPermille), 32'h0);
        $display("test prequal done");
    endtask : test_prequal
    task automatic test_charge;
        @(posedge clk);
        senseReq.inputValid       <= 1'b1;
        senseReq.battBelowTrickle <= 1'b0;
        waitState(4'h3);
        senseReq.battAtReg <= 1'b1;
        waitState(4'h4);
        senseReq.chgBelowTopoff <= 1'b1;
        waitState(4'h5);
        chk(32'(power.regulateVoltage), 32'h1);
        waitState(4'h6);
        settle;
        chk(32'(power.currentPermille), 32'h0);
        senseReq.battAtReg        <= 1'b0;
        senseReq.chgBelowTopoff   <= 1'b0;
        senseReq.battBelowRestart <= 1'b1;
        waitState(4'h3);
        chk(32'(power.softStart), 32'h0);
        senseReq.battBelowRestart <= 1'b0;
        $display("test charge done");
    endtask : test_charge
    task automatic permCase(input logic [4:0] deg, input logic cool, input logic [11:0] exp);
        senseReq.degreesOverFoldback <= deg;
        senseReq.tempBelowCool       <= cool;
        settle;
        chk(32'(power.currentPermille), 32'(exp));
    endtask : permCase
    task automatic test_temp;
        permCase(5'h04, 1'b0, 12'h320);
        permCase(5'h14, 1'b0, 12'h000);
        permCase(5'h00, 1'b1, 12'h1f4);
        apb(1'b1, OFF_CTRL, 32'h1);
        permCase(5'h00, 1'b1, 12'h3e8);
        senseReq.tempAboveWarm <= 1'b1;
        settle;
        chk(32'(power.regTargetMv), 32'h1068);
        apb(1'b1, OFF_CTRL, 32'h0);
        settle;
        chk(32'(power.regTargetMv), 32'h0fd2);
        senseReq.tempAboveHot <= 1'b1;
        settle;
        chk(32'(power.chargeOn), 32'h0);
        senseReq.tempAboveHot  <= 1'b0;
        senseReq.tempAboveWarm <= 1'b0;
        senseReq.tempBelowCold <= 1'b1;
        settle;
        chk(32'(power.chargeOn), 32'h0);
        senseReq.tempBelowCold <= 1'b0;
        senseReq.tempBelowCool <= 1'b0;
        senseReq.junctionOverShdn <= 1'b1;
        waitState(4'h8);
        chk(32'(power.chargeOn), 32'h0);
        senseReq.junctionOverShdn <= 1'b0;
        waitState(4'h3);
        $display("test temperature done");
    endtask : test_temp
    task automatic test_boost;
        senseReq.inputValid <= 1'b0;
        boostReq            <= 1'b1;
        settle;
        chk(32'(power.reverseBoost), 32'h1);
        chk(32'(power.bypassToInputOn), 32'h1);
        standbyReq <= 1'b1;
        settle;
        chk(32'(power.bypassToInputOn), 32'h0);
        standbyReq <= 1'b0;
        senseReq.chgInputOverload <= 1'b1;
        settle;
        chk(32'(power.bypassToInputOn), 32'h0);
        senseReq.chgInputOverload <= 1'b0;
        boostReq                  <= 1'b0;
        $display("test boost done");
    endtask : test_boost
    task automatic test_ovc;
        senseReq.sysBelowPowerup <= 1'b1;
        senseReq.battOverCurrent <= 1'b1;
        // Look before the first automatic retry clears the trip
        repeat (16) @(posedge clk);
        settle;
        chk(32'(power.powerupLimit), 32'h1);
        chk(32'(power.battSwitchOn), 32'h0);
        chk(32'(power.buckOn), 32'h0);
        senseReq.battOverCurrent <= 1'b0;
        repeat (40) @(posedge clk);
        settle;
        chk(32'(power.battSwitchOn), 32'h1);
        $display("test overcurrent done");
    endtask : test_ovc
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        test_reset;
        test_prequal;
        test_charge;
        test_temp;
        test_boost;
        test_ovc;
        test_done;
    end
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        test_done;
    end
endmodule : tb_top
